// ---- core/eef_pkg.sv ----
// Constants, types and decode helper for the external event input filter.
// Assumes a single 100 MHz clock and an AXI4-Lite register slave in front.
// Overview of operation
// - When the polarity select is one, a high level reached by a rising edge is the event.
// - Filter settings 01, 10 and 11 sample the pin periodically and need edge and steady state.
// - Filter setting 00 is plain edge detection and the source must hold a pulse 30.5 us.
// - Filter setting 01 samples the pin every 3.9 ms, which is 256 Hz.
// - Filter setting 10 samples the pin every 15.6 ms, which is 64 Hz.
// - Filter setting 11 samples the pin every 125 ms, which is 8 Hz.
// - Control bits 7 and 3 always read zero and ignore writes.
package eef_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_PULSE_NS = 30500;
  localparam int SAMP_256_NS = 3900000;
  localparam int SAMP_64_NS = 15600000;
  localparam int SAMP_8_NS = 125000000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMP_256_CYC = SAMP_256_NS / CLK_PERIOD_NS;
  localparam int SAMP_64_CYC = SAMP_64_NS / CLK_PERIOD_NS;
  localparam int SAMP_8_CYC = SAMP_8_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ****************************************
  // Register map
  // ****************************************
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int REG_W = 8;
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] STAT_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] MASK_OFS = 8'h08;
  localparam logic [AXI_AW-1:0] LEVEL_OFS = 8'h0c;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] CTRL_WMASK = 8'h77;
  localparam int POL_BIT = 6;
  localparam int FT_MSB = 5;
  localparam int FT_LSB = 4;
  localparam int UNUSED_HI = 7;
  localparam int UNUSED_LO = 3;
  localparam int EVT_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FT_NONE = 2'b00,
    FT_256 = 2'b01,
    FT_64 = 2'b10,
    FT_8 = 2'b11
  } eef_ft_t;

  // One-hot select {level, mask, status, control}; zero for unmapped.
  function automatic logic [3:0] eef_reg_sel(input logic [AXI_AW-1:0] a);
    eef_reg_sel = {a == LEVEL_OFS, a == MASK_OFS, a == STAT_OFS, a == CTRL_OFS};
  endfunction : eef_reg_sel

endpackage : eef_pkg

// ---- core/eef_link_if.sv ----
// Internal carrier between the bus slave, the filter and the register file.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
interface eef_link_if import eef_pkg::*; ();
  // Register access group.
  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [REG_W-1:0] wr_data;
  logic wr_hit;
  logic [AXI_AW-1:0] rd_addr;
  logic [REG_W-1:0] rd_data;
  logic rd_hit;
  // Sampling group.
  logic tick;
  logic filt_on;
  logic pol;
  logic pin;
  logic samp;
  logic level;
  logic evt;

  modport bus (output wr_en, wr_addr, wr_data, rd_addr, input rd_data, wr_hit, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, rd_addr, samp, level, evt,
    output rd_data, wr_hit, rd_hit, tick, filt_on, pol, pin);
  modport filt (input tick, filt_on, pol, pin, output samp, level, evt);
endinterface : eef_link_if

// ---- core/eef_axil.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes one write and one read outstanding at most, as the master keeps.
`timescale 1ns/1ps
module eef_axil import eef_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Write address channel.
  input wire logic [AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // Write data channel.
  input wire logic [AXI_DW-1:0] s_wdata,
  input wire logic [AXI_DW/8-1:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response channel.
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read address channel.
  input wire logic [AXI_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // Read data channel.
  output logic [AXI_DW-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side.
  eef_link_if.bus lnk
);
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [REG_W-1:0] wdata_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic do_wr;

  // Both halves held and no response pending: perform the write once.
  assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
  // Only byte lane 0 carries register bits; other lanes are dropped.
  assign lnk.wr_en = do_wr && wlane_ff;
  assign lnk.wr_addr = awaddr_ff;
  assign lnk.wr_data = wdata_ff;
  assign lnk.rd_addr = s_araddr;

  // Address capture; ready returns after the response is taken.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_ff <= 1'b1;
      awaddr_ff <= '0;
    end else if (awready_ff && s_awvalid) begin
      awready_ff <= 1'b0;
      awaddr_ff <= s_awaddr;
    end else if (bvalid_ff && s_bready) begin
      awready_ff <= 1'b1;
    end
  end

  // Data capture, independent of the address so either may come first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wready_ff <= 1'b1;
      wdata_ff <= '0;
      wlane_ff <= 1'b0;
    end else if (wready_ff && s_wvalid) begin
      wready_ff <= 1'b0;
      wdata_ff <= s_wdata[REG_W-1:0];
      wlane_ff <= s_wstrb[0];
    end else if (bvalid_ff && s_bready) begin
      wready_ff <= 1'b1;
    end
  end

  // Write response.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= lnk.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read: data is captured on the address handshake itself.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (arready_ff && s_arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= AXI_DW'(lnk.rd_data);
      rresp_ff <= lnk.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
endmodule : eef_axil

// ---- core/eef_filter.sv ----
// Sampling filter and polarity edge finder for the event input pin.
// Assumes the pin is already synchronous and a one-cycle sample tick.
`timescale 1ns/1ps
module eef_filter import eef_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Sampling side.
  eef_link_if.filt lnk
);
  logic samp_ff, level_ff, evt_ff;
  logic take;

  // Agreeing samples only.
  // Unfiltered mode takes every sample; filtered modes need two in a row.
  assign take = lnk.tick && (!lnk.filt_on || samp_ff == lnk.pin);

  // Previous sample, kept for the agreement test.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_ff <= 1'b0;
    end else if (lnk.tick) begin
      samp_ff <= lnk.pin;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= 1'b0;
    end else if (take) begin
      level_ff <= lnk.pin;
    end
  end

  // Polarity edge event.
  // The pulse lines up with the cycle in which the new level shows.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_ff <= 1'b0;
    end else begin
      evt_ff <= take && (lnk.pin != level_ff) && (lnk.pin == lnk.pol);
    end
  end

  assign lnk.samp = samp_ff;
  assign lnk.level = level_ff;
  assign lnk.evt = evt_ff;
endmodule : eef_filter

// ---- core/eef_top.sv ----
// Top of the external event input filter: register file, sample timer,
// interrupt and the two submodules.
// Assumes an AXI4-Lite master and an event pin synchronous to clk.
`timescale 1ns/1ps
module eef_top import eef_pkg::*; #(
  parameter int SAMP_256_P = SAMP_256_CYC,
  parameter int SAMP_64_P = SAMP_64_CYC,
  parameter int SAMP_8_P = SAMP_8_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Write address channel.
  input wire logic [AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // Write data channel.
  input wire logic [AXI_DW-1:0] s_wdata,
  input wire logic [AXI_DW/8-1:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response channel.
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read address channel.
  input wire logic [AXI_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // Read data channel.
  output logic [AXI_DW-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Event pin and results.
  input wire logic event_input_pin,
  output logic event_pulse,
  output logic event_level,
  // Interrupt.
  output logic irq
);

  // ****************************************
  // Declarations
  // ****************************************
  eef_link_if lnk ();
  logic [REG_W-1:0] ctrl_ff;
  logic stat_ff, mask_ff, irq_ff;
  logic [CNT_W-1:0] cnt_ff, period;
  logic tick_ff;
  logic [3:0] wsel, rsel;
  logic ctrl_wr, stat_wr, mask_wr;
  logic [CNT_W-1:0] gap_ff;
  eef_ft_t ft;

  // ****************************************
  // Submodules
  // ****************************************
  eef_axil u_axil (
    .clk(clk),
    .reset_n(reset_n),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .lnk(lnk.bus)
  );

  eef_filter u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .lnk(lnk.filt)
  );

  // ****************************************
  // Register decode
  // ****************************************
  // Same decode serves both directions so their maps cannot drift apart.
  assign wsel = eef_reg_sel(lnk.wr_addr);
  assign rsel = eef_reg_sel(lnk.rd_addr);
  assign lnk.wr_hit = |wsel;
  assign lnk.rd_hit = |rsel;
  assign ctrl_wr = lnk.wr_en && wsel[0];
  assign stat_wr = lnk.wr_en && wsel[1];
  assign mask_wr = lnk.wr_en && wsel[2];

  // Unused bits dropped.
  // Control store; the write mask keeps bits 7 and 3 at zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= lnk.wr_data & CTRL_WMASK;
    end
  end

  // Sticky event status; a new event beats a clearing write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff <= 1'b0;
    end else begin
      stat_ff <= lnk.evt || (stat_ff && !(stat_wr && lnk.wr_data[EVT_BIT]));
    end
  end

  // Interrupt mask, same layout as status.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= 1'b0;
    end else if (mask_wr) begin
      mask_ff <= lnk.wr_data[EVT_BIT];
    end
  end

  // Level interrupt, one cycle behind the status bit.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= stat_ff && mask_ff;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    lnk.rd_data = '0;
    case (rsel)
      4'h1: lnk.rd_data = ctrl_ff;
      4'h2: lnk.rd_data[EVT_BIT] = stat_ff;
      4'h4: lnk.rd_data[EVT_BIT] = mask_ff;
      4'h8: lnk.rd_data[EVT_BIT] = lnk.level;
      default: lnk.rd_data = '0;
    endcase
  end

  // ****************************************
  // Sample timer
  // ****************************************
  assign ft = eef_ft_t'(ctrl_ff[FT_MSB:FT_LSB]);
  assign lnk.filt_on = ft != FT_NONE;
  assign lnk.pol = ctrl_ff[POL_BIT];
  assign lnk.pin = event_input_pin;
  assign lnk.tick = tick_ff;

  // Period per setting.
  // Plain edge mode still samples at the minimum pulse time, so shorter
  // glitches may be missed; that is the price of a slow time base.
  always_comb begin
    case (ft)
      FT_NONE: period = CNT_W'(MIN_PULSE_CYC);
      FT_256: period = CNT_W'(SAMP_256_P);
      FT_64: period = CNT_W'(SAMP_64_P);
      FT_8: period = CNT_W'(SAMP_8_P);
      default: period = CNT_W'(MIN_PULSE_CYC);
    endcase
  end

  // Divider restart.
  // Any control write restarts the divider so a new period starts cleanly.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ctrl_wr) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= cnt_ff == period - 1'b1;
      cnt_ff <= (cnt_ff == period - 1'b1) ? '0 : cnt_ff + 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign event_pulse = lnk.evt;
  assign event_level = lnk.level;
  assign irq = irq_ff;

  // ****************************************
  // Checks
  // ****************************************
  // Cycles since the last tick or restart, for the period checks.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ff <= '0;
    end else if (ctrl_wr) begin
      gap_ff <= '0;
    end else if (tick_ff) begin
      gap_ff <= CNT_W'(1);
    end else begin
      gap_ff <= gap_ff + 1'b1;
    end
  end

  // Event on chosen edge.
  // Past polarity, since a control write may land in the cycle of the event.
  evt_polarity_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    lnk.evt |-> lnk.level == $past(lnk.pol) && $past(lnk.level) != $past(lnk.pol))
    else $error("Event without a matching level change.");

  filt_accept_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    lnk.filt_on && tick_ff && !ctrl_wr && lnk.samp == lnk.pin
      |=> lnk.level == $past(lnk.pin))
    else $error("Stable sampled level was not accepted.");

  edge_period_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick_ff && ft == FT_NONE |-> gap_ff == CNT_W'(MIN_PULSE_CYC))
    else $error("Unfiltered sample period is wrong.");

  edge_take_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick_ff && ft == FT_NONE && !ctrl_wr |=> lnk.level == $past(lnk.pin))
    else $error("Unfiltered sample not taken.");

  samp_256_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick_ff && ft == FT_256 |-> gap_ff == CNT_W'(SAMP_256_P))
    else $error("256 Hz sample period is wrong.");

  samp_64_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick_ff && ft == FT_64 |-> gap_ff == CNT_W'(SAMP_64_P))
    else $error("64 Hz sample period is wrong.");

  samp_8_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick_ff && ft == FT_8 |-> gap_ff == CNT_W'(SAMP_8_P))
    else $error("8 Hz sample period is wrong.");

  ctrl_unused_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rsel[0] |-> !lnk.rd_data[UNUSED_HI] && !lnk.rd_data[UNUSED_LO])
    else $error("Unused control bits read as one.");

  filt_agree_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(lnk.filt_on) && $changed(lnk.level)
      |-> $past(tick_ff) && $past(lnk.samp) == lnk.level)
    else $error("Filtered level changed without agreeing samples.");

  // Masked status drives the interrupt one cycle later.
  irq_follow_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    stat_ff && mask_ff |=> irq)
    else $error("Interrupt missing for unmasked status.");

  // Without an unmasked status bit the interrupt drops one cycle later.
  irq_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(stat_ff && mask_ff) |=> !irq)
    else $error("Interrupt stayed high without unmasked status.");

  // A new event sets the status bit even against a clearing write.
  stat_set_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    lnk.evt |=> stat_ff)
    else $error("Event did not set the status bit.");

  // Status stays set until a one is written to its bit.
  stat_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    stat_ff && !(stat_wr && lnk.wr_data[EVT_BIT]) |=> stat_ff)
    else $error("Status bit cleared without a clearing write.");

  // Mask takes the written bit.
  mask_load_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    mask_wr |=> mask_ff == $past(lnk.wr_data[EVT_BIT]))
    else $error("Mask write did not land.");

  filt_reject_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    lnk.filt_on && tick_ff && lnk.samp != lnk.pin |=> $stable(lnk.level))
    else $error("Filtered level moved on a disagreeing sample.");

  evt_single_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    lnk.evt |=> !lnk.evt)
    else $error("Event pulse lasted more than one cycle.");

endmodule : eef_top

// ---- tb/eef_pin_src.sv ----
// Behavioural source that drives the event pin on command of the bench.
// Assumes the bench clock; the pin only moves just after a rising edge.
`timescale 1ns/1ps
module eef_pin_src import eef_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Commands from the bench.
  input wire logic want,
  input wire logic allow_short,
  // Event pin.
  output logic pin
);
  // ****************************************
  // Pin driver
  // ****************************************
  logic pin_ff;
  int hold_ff;

  // minimum pulse hold
  // A real source keeps each level 30.5 us; allow_short lets a glitch through on purpose.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff <= 1'b0;
      hold_ff <= 0;
    end else if (want != pin_ff && (hold_ff >= MIN_PULSE_CYC || allow_short)) begin
      pin_ff <= want;
      hold_ff <= 1;
    end else if (hold_ff < MIN_PULSE_CYC) begin
      hold_ff <= hold_ff + 1;
    end
  end

  // The pin is a plain push-pull output, never released.
  assign pin = pin_ff;
endmodule : eef_pin_src

// ---- tb/test_external_event_input_filter.sv ----
// Self-checking bench for the event input filter, driving AXI4-Lite and the pin.
// Assumes shortened sample periods of 20, 40 and 80 cycles.
`timescale 1ns/1ps
module test_external_event_input_filter import eef_pkg::*;;
  localparam int P1 = 20;
  localparam int P2 = 40;
  localparam int P3 = 80;
  logic clk, reset_n, want, allow_short, pin, event_pulse, event_level, irq;
  logic [AXI_AW-1:0] s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [AXI_DW-1:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  int n_mismatch, tests_run;

  eef_top #(.SAMP_256_P(P1), .SAMP_64_P(P2), .SAMP_8_P(P3)) DUT (.clk(clk), .reset_n(reset_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .event_input_pin(pin), .event_pulse(event_pulse),
    .event_level(event_level), .irq(irq));
  eef_pin_src src (.clk(clk), .reset_n(reset_n), .want(want), .allow_short(allow_short),
    .pin(pin));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // A bus wait that runs out counts once and ends the run.
  task automatic give_up();
    check("bus answer", 0, 1);
    tally_and_finish();
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'hf;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) begin
        r = s_bresp;
        s_bready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000) give_up();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    d = 32'hx;
    r = 2'h3;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000) give_up();
  endtask : rd

  // Counts event pulses over n cycles and the cycle of the first one.
  task automatic run(input int n, output int pulses, output int first);
    pulses = 0;
    first = -1;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      if (event_pulse === 1'b1) begin
        pulses++;
        if (first < 0) first = i;
      end
    end
  endtask : run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(CTRL_OFS, d, r);
    check("ctrl reset", d, 32'h0);
    check("irq reset", irq, 1'b0);
    wr(CTRL_OFS, 8'hff, r);
    check("ctrl write resp", r, RESP_OKAY);
    rd(CTRL_OFS, d, r);
    check("ctrl unused bits", d, 32'h77);
    check("ctrl read resp", r, RESP_OKAY);
    wr(8'h10, 8'h01, r);
    check("unmapped write resp", r, RESP_SLVERR);
    rd(8'h10, d, r);
    check("unmapped resp", r, RESP_SLVERR);
    check("unmapped data", d, 32'h0);
    $display("done registers");
  endtask : t_regs

  // Plain edge mode, rising polarity, interrupt raised and cleared.
  task automatic t_plain();
    logic [31:0] d;
    logic [1:0] r;
    int p, f;
    wr(MASK_OFS, 8'h01, r);
    wr(CTRL_OFS, 8'h40, r);
    want <= 1'b1;
    run(3060, p, f);
    check("plain pulses", p, 1);
    check("plain level", event_level, 1'b1);
    rd(STAT_OFS, d, r);
    check("status set", d, 32'h1);
    check("irq on", irq, 1'b1);
    wr(STAT_OFS, 8'h01, r);
    rd(STAT_OFS, d, r);
    check("status clear", d, 32'h0);
    check("irq off", irq, 1'b0);
    want <= 1'b0;
    run(3100, p, f);
    check("falling ignored", p, 0);
    check("plain low", event_level, 1'b0);
    $display("done plain mode");
  endtask : t_plain

  // Filtered mode m: a glitch seen by exactly one sample is dropped, a steady
  // level is taken in time. The glitch spans the first tick after the write.
  task automatic t_filt(input int m);
    logic [1:0] r;
    int p, q, f, per;
    per = (m == 1) ? P1 : (m == 2) ? P2 : P3;
    wr(CTRL_OFS, 8'h40 | 8'(m << 4), r);
    allow_short <= 1'b1;
    want <= 1'b1;
    run(per, p, f);
    want <= 1'b0;
    run(3 * per, q, f);
    check("glitch pulses", p + q, 0);
    want <= 1'b1;
    run(2 * per + 6, p, f);
    check("filt pulses", p, 1);
    check("filt delay", 32'(f >= per && f <= 2 * per + 4), 1);
    check("filt level", event_level, 1'b1);
    want <= 1'b0;
    run(3 * per, p, f);
    check("filt fall", p, 0);
    check("filt low", event_level, 1'b0);
    $display("done filter mode %0d", m);
  endtask : t_filt

  // Falling polarity with the interrupt masked.
  task automatic t_pol0();
    logic [31:0] d;
    logic [1:0] r;
    int p, f;
    wr(MASK_OFS, 8'h00, r);
    wr(STAT_OFS, 8'h01, r);
    wr(CTRL_OFS, 8'h10, r);
    want <= 1'b1;
    run(3 * P1, p, f);
    check("rise ignored", p, 0);
    rd(LEVEL_OFS, d, r);
    check("level reg", d, 32'h1);
    want <= 1'b0;
    run(3 * P1, p, f);
    check("fall taken", p, 1);
    rd(STAT_OFS, d, r);
    check("status low pol", d, 32'h1);
    check("irq masked", irq, 1'b0);
    $display("done low polarity");
  endtask : t_pol0

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    want = 1'b0;
    allow_short = 1'b0;
    s_awaddr = '0;
    s_awvalid = 1'b0;
    s_wdata = '0;
    s_wstrb = '0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = '0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_plain();
    for (int m = 1; m <= 3; m++) t_filt(m);
    t_pol0();
    tally_and_finish();
  end
endmodule : test_external_event_input_filter
